// ===== rtl/trip_logic_pkg.sv
package trip_logic_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int LEVEL_BLOCK_MS = 100;
  localparam int STRETCH_MS = 20;
  localparam int EXT_BLOCK_MS = 100;
  localparam int ALARM_MS = 2000;
  localparam int PRETRIP_340_US = 4500;
  localparam int PRETRIP_680_US = 2500;
  localparam int TRIP_SEQ_MS = 10;
  localparam int GUARD_QUAL_MS = 10;
  localparam int HARD_GUARD_MS = 100;
  localparam int HYST_MS = 20;
  localparam int BLOCK_TIMER_MS = 100;
  localparam int RESTORE_MS = 100;
  // every wait rounds down: the clock is divided to cycles per ms or per us first
  localparam int LEVEL_BLOCK_CYC = (CLK_HZ / 1000) * LEVEL_BLOCK_MS;
  localparam int STRETCH_CYC = (CLK_HZ / 1000) * STRETCH_MS;
  localparam int EXT_BLOCK_CYC = (CLK_HZ / 1000) * EXT_BLOCK_MS;
  localparam int ALARM_CYC = (CLK_HZ / 1000) * ALARM_MS;
  localparam int PRETRIP_340_CYC = (CLK_HZ / 1000000) * PRETRIP_340_US;
  localparam int PRETRIP_680_CYC = (CLK_HZ / 1000000) * PRETRIP_680_US;
  localparam int TRIP_SEQ_CYC = (CLK_HZ / 1000) * TRIP_SEQ_MS;
  localparam int GUARD_QUAL_CYC = (CLK_HZ / 1000) * GUARD_QUAL_MS;
  localparam int HARD_GUARD_CYC = (CLK_HZ / 1000) * HARD_GUARD_MS;
  localparam int HYST_CYC = (CLK_HZ / 1000) * HYST_MS;
  localparam int BLOCK_TIMER_CYC = (CLK_HZ / 1000) * BLOCK_TIMER_MS;
  localparam int RESTORE_CYC = (CLK_HZ / 1000) * RESTORE_MS;

  typedef struct packed {
    logic high_trip;
    logic low_trip;
    logic guard;
    logic [1:0] level_fault;
    logic [1:0] noise_high;
    logic [1:0] noise_low;
  } detect_t;

  typedef struct packed {
    logic block_slow;
    logic block_fast;
    logic noise_block;
    logic diag_block;
    logic undervolt;
  } block_in_t;

  typedef struct packed {
    logic block;
    logic block_relay_on;
    logic block_lamp;
    logic alarm;
    logic alarm_lamp;
    logic alarm_relay_on;
    logic trip;
  } status_t;
endpackage : trip_logic_pkg

// ===== rtl/delay_timer.sv
`timescale 1ns/1ps
// output rises only after input held high for the full count; drops at once
module delay_timer #(
  parameter int COUNT = 1,
  parameter int W     = 26
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic in_lvl,
  input  wire logic rst_val,
  output logic      out_lvl
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (!in_lvl) begin
        cnt_q <= '0;
      end else if (cnt_q != W'(COUNT)) begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_lvl <= rst_val;
    end else if (ce) begin
      out_lvl <= in_lvl && (cnt_q >= W'(COUNT - 1));
    end
  end
endmodule : delay_timer

// ===== rtl/trip_block_logic.sv
`timescale 1ns/1ps
module trip_block_logic
  import trip_logic_pkg::*;
#(
  parameter int LEVEL_CYC   = LEVEL_BLOCK_CYC,
  parameter int STR_CYC     = STRETCH_CYC,
  parameter int EXT_CYC     = EXT_BLOCK_CYC,
  parameter int ALM_CYC     = ALARM_CYC,
  parameter int PT340_CYC   = PRETRIP_340_CYC,
  parameter int PT680_CYC   = PRETRIP_680_CYC,
  parameter int SEQ_CYC     = TRIP_SEQ_CYC,
  parameter int GQ_CYC      = GUARD_QUAL_CYC,
  parameter int HG_CYC      = HARD_GUARD_CYC,
  parameter int HY_CYC      = HYST_CYC,
  parameter int BT_CYC      = BLOCK_TIMER_CYC,
  parameter int RS_CYC      = RESTORE_CYC
) (
  input  wire logic      clk_sys,
  input  wire logic      reset,
  input  wire logic      ce,
  input  wire detect_t   det_pin,
  input  wire block_in_t blk_pin,
  input  wire logic      spacing_680,
  input  wire logic      guard_every_trip,
  output status_t        status
);
  detect_t   det_s1_q, det_q;
  block_in_t blk_s1_q, blk_q;

  // pins cross in through two flops; nothing reads the first
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      det_s1_q <= '0;
      det_q    <= '0;
      blk_s1_q <= '0;
      blk_q    <= '0;
    end else if (ce) begin
      det_s1_q <= det_pin;
      det_q    <= det_s1_q;
      blk_s1_q <= blk_pin;
      blk_q    <= blk_s1_q;
    end
  end

  logic noise_any, noise_hi, guard_loss;
  logic level_blk, stretch_in, stretch_q, stretch_raw, guard_ok20;
  logic ext_blk, hi_trip_ok, pt_a, pt_b, low_trip_ok;
  logic guard_q10, guard_q100, hard_seen_q, hyst_q;
  logic collect, bt_out, restore_ok, block_cond;
  logic alarm_t, first_done_q, gate_guard, trip_d, uv;
  logic hyst_cnt_en, alarm_on;
  logic [25:0] hyst_cnt_q;

  assign uv         = blk_q.undervolt;
  assign noise_any  = |det_q.noise_high || |det_q.noise_low;
  assign noise_hi   = |det_q.noise_high;
  assign guard_loss = !det_q.guard;

  delay_timer #(.COUNT(LEVEL_CYC)) u_level (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .in_lvl(|det_q.level_fault),
    .rst_val(1'b0), .out_lvl(level_blk));

  // stretcher: raises with high-channel noise or guard loss, holds until 20 ms of clean guard
  assign stretch_in = noise_hi || guard_loss;
  delay_timer #(.COUNT(STR_CYC)) u_stretch (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .in_lvl(!stretch_in),
    .rst_val(1'b0), .out_lvl(guard_ok20));
  assign stretch_raw = !guard_ok20;
  assign stretch_q   = stretch_raw && !hyst_q;

  delay_timer #(.COUNT(EXT_CYC)) u_ext (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .in_lvl(blk_q.block_slow),
    .rst_val(1'b0), .out_lvl(ext_blk));

  // collected slow block requests pass the block timer
  assign collect = stretch_q || level_blk || blk_q.noise_block;
  delay_timer #(.COUNT(BT_CYC)) u_block (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .in_lvl(collect),
    .rst_val(1'b1), .out_lvl(bt_out));

  // restore: permission returns 100 ms after every prohibition clears
  delay_timer #(.COUNT(RS_CYC)) u_restore (
    .clk_sys(clk_sys), .reset(reset), .ce(ce),
    .in_lvl(!(bt_out || ext_blk || blk_q.block_fast || uv)),
    .rst_val(1'b0), .out_lvl(restore_ok));
  assign block_cond = !restore_ok || blk_q.block_fast || uv;

  delay_timer #(.COUNT(ALM_CYC)) u_alarm (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .in_lvl(block_cond),
    .rst_val(1'b0), .out_lvl(alarm_t));
  // alarm falls with the block it times, not one cycle after it
  assign alarm_on = (alarm_t && block_cond) || uv;

  // pre-trip qualifier on high-level trip, spacing picks the count
  delay_timer #(.COUNT(PT340_CYC)) u_pt340 (
    .clk_sys(clk_sys), .reset(reset), .ce(ce),
    .in_lvl(det_q.high_trip && !spacing_680), .rst_val(1'b0), .out_lvl(pt_a));
  delay_timer #(.COUNT(PT680_CYC)) u_pt680 (
    .clk_sys(clk_sys), .reset(reset), .ce(ce),
    .in_lvl(det_q.high_trip && spacing_680), .rst_val(1'b0), .out_lvl(pt_b));
  assign hi_trip_ok = (pt_a || pt_b) && !noise_any && !block_cond;

  delay_timer #(.COUNT(SEQ_CYC)) u_seq (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .in_lvl(det_q.low_trip),
    .rst_val(1'b0), .out_lvl(low_trip_ok));

  delay_timer #(.COUNT(GQ_CYC)) u_gq (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .in_lvl(det_q.guard),
    .rst_val(1'b0), .out_lvl(guard_q10));
  delay_timer #(.COUNT(HG_CYC)) u_hg (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .in_lvl(det_q.guard && !block_cond),
    .rst_val(1'b0), .out_lvl(guard_q100));

  // hard block needs the long guard before trips return
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hard_seen_q <= 1'b1;
    end else if (ce) begin
      if (bt_out || uv) begin
        hard_seen_q <= 1'b1;
      end else if (guard_q100) begin
        hard_seen_q <= 1'b0;
      end
    end
  end

  // guard armed latch: set by qualified guard, kept through trip in both modes
  logic armed_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      armed_q <= 1'b0;
    end else if (ce) begin
      if (guard_q10 && !hard_seen_q) begin
        armed_q <= 1'b1;
      end else if (block_cond || hard_seen_q) begin
        armed_q <= 1'b0;
      end else if (guard_every_trip && !trip_d && det_q.guard) begin
        armed_q <= armed_q;
      end else if (guard_every_trip && !trip_d && !det_q.guard && !guard_q10
                   && !status.trip) begin
        armed_q <= armed_q;
      end
    end
  end

  // every-trip mode: a trip ending drops the arm until guard qualifies again
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      first_done_q <= 1'b0;
    end else if (ce) begin
      if (!armed_q || guard_q10) begin
        first_done_q <= 1'b0;
      end else if (status.trip && !trip_d && guard_every_trip) begin
        first_done_q <= 1'b1;
      end
    end
  end
  assign gate_guard = armed_q && !first_done_q;

  assign trip_d = hi_trip_ok && low_trip_ok && guard_loss && gate_guard
                  && !blk_q.diag_block && !uv;

  // hysteresis: arms at trip start, holds 20 ms after dropout
  assign hyst_cnt_en = (hyst_cnt_q != '0);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hyst_cnt_q <= '0;
    end else if (ce) begin
      if (trip_d) begin
        hyst_cnt_q <= 26'(HY_CYC);
      end else if (hyst_cnt_en) begin
        hyst_cnt_q <= hyst_cnt_q - 26'h1;
      end
    end
  end
  assign hyst_q = hyst_cnt_en;

  // outputs from flops
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status <= '{block: 1'b1, block_relay_on: 1'b0, block_lamp: 1'b1,
                  alarm: 1'b0, alarm_lamp: 1'b0, alarm_relay_on: 1'b1,
                  trip: 1'b0};
    end else if (ce) begin
      status.block          <= block_cond;
      status.block_relay_on <= !block_cond;
      status.block_lamp     <= block_cond;
      status.alarm          <= alarm_on;
      status.alarm_lamp     <= alarm_on;
      status.alarm_relay_on <= !alarm_on;
      status.trip           <= trip_d;
    end
  end

  a_uv_no_trip: assert property (@(posedge clk_sys) disable iff (reset)
    ce && blk_q.undervolt |=> !status.trip && status.block && status.alarm)
    else $error("undervoltage did not block");
  a_fast_block: assert property (@(posedge clk_sys) disable iff (reset)
    ce && blk_q.block_fast |=> status.block)
    else $error("fast block not immediate");
  a_diag_block: assert property (@(posedge clk_sys) disable iff (reset)
    ce && blk_q.diag_block |=> !status.trip)
    else $error("diagnostic block let trip through");
  a_noise_trip: assert property (@(posedge clk_sys) disable iff (reset)
    ce && noise_any |=> !status.trip)
    else $error("noise did not inhibit trip");
  // timer outputs lag their inputs by one edge, so look one edge on
  sequence s_tones_missing;
    ce && !(det_q.high_trip && det_q.low_trip) ##1 ce;
  endsequence
  a_trip_needs: assert property (@(posedge clk_sys) disable iff (reset)
    s_tones_missing |=> !status.trip)
    else $error("trip without both detections");
  a_trip_guard: assert property (@(posedge clk_sys) disable iff (reset)
    ce && det_q.guard |=> !status.trip)
    else $error("trip with guard present");
  a_alarm_blk: assert property (@(posedge clk_sys) disable iff (reset)
    ce && status.alarm && !blk_q.undervolt |-> status.block)
    else $error("alarm without block");
  a_block_relay: assert property (@(posedge clk_sys) disable iff (reset)
    status.block |-> !status.block_relay_on && status.block_lamp)
    else $error("block relay or lamp wrong");
  a_trip_blk: assert property (@(posedge clk_sys) disable iff (reset)
    ce && block_cond |=> !status.trip)
    else $error("trip during block");
endmodule : trip_block_logic

// ===== testbench/tone_rx_model.sv
`timescale 1ns/1ps
// scene bits: 0 high trip, 1 low trip, 2 noise low, 3 noise high, 4 level,
// 5 slow block, 6 fast block, 7 noise block, 8 diag block, 9 undervolt
module tone_rx_model
  import trip_logic_pkg::*;
(
  input  wire logic [9:0] scene,
  output detect_t         det,
  output block_in_t       blk
);
  // the line carries guard or trip tone, never both
  assign det.high_trip   = scene[0];
  assign det.low_trip    = scene[1];
  assign det.guard       = ~(scene[0] | scene[1]);
  // faults on one channel only, so either-channel merging is exercised
  assign det.level_fault = {1'b0, scene[4]};
  assign det.noise_high  = {scene[3], 1'b0};
  assign det.noise_low   = {1'b0, scene[2]};
  assign blk.block_slow  = scene[5];
  assign blk.block_fast  = scene[6];
  assign blk.noise_block = scene[7];
  assign blk.diag_block  = scene[8];
  assign blk.undervolt   = scene[9];
endmodule : tone_rx_model

// ===== testbench/tb_trip_block_logic.sv
`timescale 1ns/1ps
module tb_trip_block_logic
  import trip_logic_pkg::*;
;
  typedef struct {
    logic [9:0] sc;
    int         cyc;
    logic       care;
    logic       blk;
    logic       trp;
  } row_t;
  logic       clk_sys     = 1'b0;
  logic       reset       = 1'b1;
  // short counts keep the run small; ordering of the real delays is kept only in part (restore 12 below block timer 24, stretch 6 below sequence 8)
  localparam int T_LEVEL = 24;
  localparam int T_STR   = 6;
  localparam int T_EXT   = 24;
  localparam int T_ALM   = 60;
  localparam int T_PT340 = 6;
  localparam int T_PT680 = 3;
  localparam int T_SEQ   = 8;
  localparam int T_GQ    = 8;
  localparam int T_HG    = 20;
  localparam int T_HY    = 6;
  localparam int T_BT    = 24;
  localparam int T_RS    = 12;
  logic       ce          = 1'b1;
  logic       guard_every = 1'b0;
  logic       spacing_680 = 1'b0;
  logic [9:0] scene       = 10'h000;
  logic       seen_trip   = 1'b0;
  detect_t    det_pin;
  block_in_t  blk_pin;
  status_t    status;
  int         n_fail      = 0;
  int         n_tests     = 0;
  row_t       rows [12]   = '{
    '{10'h003, 20, 1'b1, 1'b0, 1'b1}, '{10'h007, 20, 1'b0, 1'b0, 1'b0},
    '{10'h00b, 20, 1'b0, 1'b0, 1'b0}, '{10'h008, 5, 1'b1, 1'b0, 1'b0},
    '{10'h043, 4, 1'b1, 1'b1, 1'b0}, '{10'h080, 35, 1'b1, 1'b1, 1'b0},
    '{10'h103, 20, 1'b0, 1'b0, 1'b0}, '{10'h203, 4, 1'b1, 1'b1, 1'b0},
    '{10'h020, 10, 1'b1, 1'b0, 1'b0}, '{10'h020, 60, 1'b1, 1'b1, 1'b0},
    '{10'h010, 10, 1'b1, 1'b0, 1'b0}, '{10'h010, 70, 1'b1, 1'b1, 1'b0}};

  tone_rx_model u_tone_rx_model (.scene(scene), .det(det_pin), .blk(blk_pin));

  trip_block_logic #(.LEVEL_CYC(T_LEVEL), .STR_CYC(T_STR), .EXT_CYC(T_EXT),
    .ALM_CYC(T_ALM), .PT340_CYC(T_PT340), .PT680_CYC(T_PT680), .SEQ_CYC(T_SEQ),
    .GQ_CYC(T_GQ), .HG_CYC(T_HG), .HY_CYC(T_HY), .BT_CYC(T_BT),
    .RS_CYC(T_RS)) u_trip_block_logic (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .det_pin(det_pin),
    .blk_pin(blk_pin), .spacing_680(spacing_680), .guard_every_trip(guard_every),
    .status(status));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : chk

  task automatic step(input logic [9:0] sc, input int n);
    scene = sc;
    repeat (n) @(negedge clk_sys);
  endtask : step

  // like step, but remembers any trip seen at the sampling points
  task automatic watch(input logic [9:0] sc, input int n);
    scene = sc;
    repeat (n) begin
      @(negedge clk_sys);
      seen_trip = seen_trip | (status.trip === 1'b1);
    end
  endtask : watch

  task automatic results;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    $display("unexpected run length: expected end of tests, seen hang");
    results();
  end

  initial begin
    repeat (10) @(negedge clk_sys);
    chk("block in reset", status.block, 1'b1);
    chk("block relay in reset", status.block_relay_on, 1'b0);
    chk("block lamp in reset", status.block_lamp, 1'b1);
    chk("alarm in reset", status.alarm, 1'b0);
    chk("alarm relay in reset", status.alarm_relay_on, 1'b1);
    chk("trip in reset", status.trip, 1'b0);
    reset = 1'b0;
    step(10'h000, 12);
    chk("block held after reset", status.block, 1'b1);
    step(10'h000, 150);
    chk("block cleared by guard", status.block, 1'b0);
    $display("reset test done");
    // a low enable must hold every flop, the input synchronisers too
    ce = 1'b0;
    step(10'h040, 10);
    chk("block while frozen", status.block, 1'b0);
    ce = 1'b1;
    step(10'h040, 4);
    chk("block after enable", status.block, 1'b1);
    step(10'h000, 150);
    $display("enable test done");
    foreach (rows[i]) begin
      step(rows[i].sc, rows[i].cyc);
      if (rows[i].care) chk("block", status.block, rows[i].blk);
      chk("trip", status.trip, rows[i].trp);
      step(10'h000, 8);
      // a long block must wait out the restore time after it clears
      if (rows[i].care && rows[i].blk) chk("block held", status.block, 1'b1);
      step(10'h000, 142);
      chk("block after recovery", status.block, 1'b0);
      $display("row %0d done", i);
    end
    // high trip lasting 5 cycles: long enough only with wide spacing
    for (int s = 0; s < 2; s++) begin
      spacing_680 = s[0];
      step(10'h002, 10);
      seen_trip = 1'b0;
      watch(10'h003, 5);
      watch(10'h000, 10);
      chk("short high trip", seen_trip, s[0]);
      step(10'h000, 150);
      $display("pre-trip test %0d done", s);
    end
    // long trip outlasts the block timer; a dropout needs fresh guard per mode
    for (int m = 1; m >= 0; m--) begin
      guard_every = m[0];
      step(10'h003, 40);
      chk("trip held past block time", status.trip, 1'b1);
      chk("block during long trip", status.block, 1'b0);
      step(10'h002, 3);
      step(10'h003, 8);
      chk("trip after dropout", status.trip, !m[0]);
      step(10'h000, 150);
      $display("guard mode test %0d done", m);
    end
    // bursts closer than the stretch time merge into one long request
    for (int g = 0; g < 2; g++) begin
      repeat ((g == 0) ? 6 : 3) begin
        step(10'h008, 3);
        step(10'h000, (g == 0) ? 4 : 12);
      end
      chk("block after noise bursts", status.block, g == 0);
      step(10'h000, 150);
      $display("noise burst test %0d done", g);
    end
    step(10'h040, 30);
    chk("alarm before delay", status.alarm, 1'b0);
    step(10'h040, 45);
    chk("alarm", status.alarm, 1'b1);
    chk("alarm lamp", status.alarm_lamp, 1'b1);
    chk("alarm relay", status.alarm_relay_on, 1'b0);
    step(10'h000, 200);
    chk("block after alarm", status.block, 1'b0);
    chk("alarm after block clears", status.alarm, 1'b0);
    $display("alarm test done");
    reset = 1'b1;
    step(10'h000, 10);
    chk("block in second reset", status.block, 1'b1);
    reset = 1'b0;
    step(10'h000, 16);
    chk("block released after reset", status.block, 1'b0);
    // block is gone but the long guard after a hard block is not yet met
    step(10'h003, 12);
    chk("trip before long guard", status.trip, 1'b0);
    step(10'h000, 150);
    step(10'h003, 12);
    chk("trip after long guard", status.trip, 1'b1);
    step(10'h000, 20);
    $display("second reset test done");
    results();
  end
endmodule : tb_trip_block_logic
